// >>> include/rat_regs.svh
// register map, field positions, reset values and timing figures of the alarm and trim block
`ifndef RAT_REGS_SVH
`define RAT_REGS_SVH

`define RAT_ADDR_STATUS 8'h07
`define RAT_ADDR_INTCTL 8'h08
`define RAT_ADDR_ATRIM 8'h0A
`define RAT_ADDR_DTRIM 8'h0B
`define RAT_ADDR_ALM_BASE 8'h0C
`define RAT_ALM_COUNT 6

`define RAT_SR_FLAG_BIT 2
`define RAT_SR_AUTOCLR_BIT 7
`define RAT_INT_PULSE_BIT 7
`define RAT_INT_ALMON_BIT 6
`define RAT_INT_FOBAT_BIT 4
`define RAT_ALM_EN_BIT 7
`define RAT_DTR_SIGN_BIT 2

`define RAT_RST_BYTE 8'h00

`define RAT_CX_BASE_HALF 7'h12
`define RAT_PPM_LO 6'h14
`define RAT_PPM_HI 6'h28
`define RAT_PPM_SCALE 24'h0F4240
`define RAT_PRESC_TOP 16'h7FFF

`define RAT_PULSE_MS 250
`define RAT_CLK_KHZ 100000

`endif

// >>> include/rat_pkg.sv
// types of the alarm and trim block
package rat_pkg;

  typedef enum logic [2:0] {
    RAT_IDLE  = 3'b001,
    RAT_HOLD  = 3'b010,
    RAT_PULSE = 3'b100
  } rat_irq_st_t;

endpackage

// >>> core/rat_core.sv
// alarm comparator, interrupt pin driver and oscillator trim controls
`timescale 1ns/1ps
`include "rat_regs.svh"

// Summary of operation
// - each crystal capacitor is 9 pF plus bit weights, top weight when bit clear.
// - load capacitance is half of that, 4.5 to 20.25 pF, default 12.5 pF.
// - two-bit battery delta changes capacitance by 0, -0.5, +0.5 or +1 pF.
// - digital trim changes the average oscillator counts taken per second.
// - top trim bit is the sign; zero magnitude means no correction either way.
// - lower trim bits weigh 40 and 20 ppm, range plus or minus 60 ppm.
// - six alarm bytes at 0Ch to 11h, seconds through weekday, no year.
// - top bit of each alarm byte enables that field's compare.
// - alarm fires when at least one field is enabled and all enabled fields equal the running time.
// - single mode sets the flag and holds the pin low until flag clears.
// - recurring mode pulses the pin on every match without re-arming.
// - with auto-clear set, a status read clears the flag.
// - recurring mode still sets the flag; pulses ignore whether it is cleared.
// - recurring pulses are active low and last 250 ms.
// - nonzero frequency select owns the pin and disables the alarm.
// - a flag set after the status read strobe, up to the end of the read, stays set after the read.
module rat_core #(
  parameter int unsigned PULSE_CYCLES = `RAT_PULSE_MS * `RAT_CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_done_i,
  output logic [7:0] reg_rdata_o,
  input wire logic osc_tick_i,
  input wire logic on_battery_i,
  input wire logic time_upd_i,
  input wire logic [7:0] time_sec_i,
  input wire logic [7:0] time_min_i,
  input wire logic [7:0] time_hour_i,
  input wire logic [7:0] time_date_i,
  input wire logic [7:0] time_month_i,
  input wire logic [7:0] time_wday_i,
  output logic sec_tick_o,
  output logic irq_n_o,
  output logic [3:0] freq_out_select_o,
  output logic [6:0] cx_half_pf_o,
  output logic [6:0] cload_qtr_pf_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] alarm_reg [`RAT_ALM_COUNT];
  logic [7:0] intctl;
  logic [7:0] load_capacitance_trim;
  logic [7:0] digital_rate_trim;
  logic auto_clear_on_read;
  logic alarm_flag;
  logic sr_pend;
  logic set_during;
  logic [7:0] time_now [`RAT_ALM_COUNT];
  logic [`RAT_ALM_COUNT-1:0] field_en;
  logic [`RAT_ALM_COUNT-1:0] field_hit;
  logic alarm_on;
  logic pulse_alarm_select;
  logic [3:0] freq_out_select;
  logic pin_off;
  logic trigger;
  logic sr_wr;

  assign alarm_on = intctl[`RAT_INT_ALMON_BIT];
  assign pulse_alarm_select = intctl[`RAT_INT_PULSE_BIT];
  assign freq_out_select = intctl[3:0];
  assign sr_wr = reg_wr_i && (reg_addr_i == `RAT_ADDR_STATUS);
  assign pin_off = (freq_out_select != 4'h0) || !alarm_on ||
                   (intctl[`RAT_INT_FOBAT_BIT] && on_battery_i);

  assign time_now[0] = time_sec_i;
  assign time_now[1] = time_min_i;
  assign time_now[2] = time_hour_i;
  assign time_now[3] = time_date_i;
  assign time_now[4] = time_month_i;
  assign time_now[5] = time_wday_i;

  genvar g;
  generate
    for (g = 0; g < `RAT_ALM_COUNT; g++) begin : g_alarm
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          alarm_reg[g] <= `RAT_RST_BYTE;
        end else if (reg_wr_i && (reg_addr_i == (`RAT_ADDR_ALM_BASE + 8'(g)))) begin
          alarm_reg[g] <= reg_wdata_i;
        end
      end
      assign field_en[g] = alarm_reg[g][`RAT_ALM_EN_BIT];
      assign field_hit[g] = !field_en[g] || (alarm_reg[g][6:0] == time_now[g][6:0]);
    end
  endgenerate

  // one compare per time update, only with alarm on and no frequency output
  assign trigger = time_upd_i && alarm_on && (freq_out_select == 4'h0) &&
                   (|field_en) && (&field_hit);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      intctl <= `RAT_RST_BYTE;
      load_capacitance_trim <= `RAT_RST_BYTE;
      digital_rate_trim <= `RAT_RST_BYTE;
      auto_clear_on_read <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `RAT_ADDR_STATUS: auto_clear_on_read <= reg_wdata_i[`RAT_SR_AUTOCLR_BIT];
        `RAT_ADDR_INTCTL: intctl <= reg_wdata_i;
        `RAT_ADDR_ATRIM: load_capacitance_trim <= reg_wdata_i;
        `RAT_ADDR_DTRIM: digital_rate_trim <= {5'h00, reg_wdata_i[2:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `RAT_RST_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RAT_ADDR_STATUS: reg_rdata_o <= {auto_clear_on_read, 4'h0, alarm_flag, 2'h0};
        `RAT_ADDR_INTCTL: reg_rdata_o <= intctl;
        `RAT_ADDR_ATRIM: reg_rdata_o <= load_capacitance_trim;
        `RAT_ADDR_DTRIM: reg_rdata_o <= digital_rate_trim;
        8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11: reg_rdata_o <= alarm_reg[3'(reg_addr_i - `RAT_ADDR_ALM_BASE)];
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sr_pend <= 1'b0;
      set_during <= 1'b0;
    end else begin
      if (reg_rd_i && (reg_addr_i == `RAT_ADDR_STATUS)) begin
        sr_pend <= 1'b1;
      end else if (reg_rd_done_i) begin
        sr_pend <= 1'b0;
      end
      if (reg_rd_done_i || !sr_pend) begin
        set_during <= 1'b0;
      end else if (trigger) begin
        set_during <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_flag <= 1'b0;
    end else if (trigger) begin
      alarm_flag <= 1'b1;
    end else if (sr_wr && !reg_wdata_i[`RAT_SR_FLAG_BIT]) begin
      alarm_flag <= 1'b0;
    end else if (reg_rd_done_i && sr_pend && auto_clear_on_read && !set_during) begin
      alarm_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin
  rat_pkg::rat_irq_st_t irq_st;
  logic [24:0] pulse_cnt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st <= rat_pkg::RAT_IDLE;
      pulse_cnt <= 25'h0000000;
    end else if (freq_out_select != 4'h0 || !alarm_on) begin
      irq_st <= rat_pkg::RAT_IDLE;
      pulse_cnt <= 25'h0000000;
    end else if (trigger && pulse_alarm_select) begin
      irq_st <= rat_pkg::RAT_PULSE;
      pulse_cnt <= 25'(PULSE_CYCLES - 1);
    end else begin
      case (irq_st)
        rat_pkg::RAT_IDLE: begin
          if (trigger) begin
            irq_st <= rat_pkg::RAT_HOLD;
          end
        end
        rat_pkg::RAT_HOLD: begin
          if (!alarm_flag) begin
            irq_st <= rat_pkg::RAT_IDLE;
          end
        end
        rat_pkg::RAT_PULSE: begin
          if (pulse_cnt == 25'h0000000) begin
            irq_st <= rat_pkg::RAT_IDLE;
          end else begin
            pulse_cnt <= pulse_cnt - 25'h0000001;
          end
        end
        default: irq_st <= rat_pkg::RAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_n_o <= 1'b1;
      freq_out_select_o <= 4'h0;
    end else begin
      irq_n_o <= (irq_st == rat_pkg::RAT_IDLE) || pin_off;
      freq_out_select_o <= freq_out_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog trim
  logic [6:0] cx_half;
  logic [6:0] cx_eff;

  // weights in half picofarads: 32 for a clear top bit, then 16, 8, 4, 2, 1
  assign cx_half = `RAT_CX_BASE_HALF +
                   {1'b0, !load_capacitance_trim[5], load_capacitance_trim[4:0]};

  always_comb begin
    cx_eff = cx_half;
    if (on_battery_i) begin
      case (load_capacitance_trim[7:6])
        2'h1: cx_eff = cx_half - 7'h01;
        2'h2: cx_eff = cx_half + 7'h01;
        2'h3: cx_eff = cx_half + 7'h02;
        default: cx_eff = cx_half;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cx_half_pf_o <= 7'h32;
      cload_qtr_pf_o <= 7'h32;
    end else begin
      cx_half_pf_o <= cx_eff;
      cload_qtr_pf_o <= cx_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital trim prescaler
  logic [15:0] presc;
  logic [15:0] presc_top;
  logic [23:0] ppm_acc;
  logic [23:0] ppm_sum;
  logic [5:0] ppm_mag;
  logic adj_pend;
  logic wrap;

  assign ppm_mag = (digital_rate_trim[1] ? `RAT_PPM_HI : 6'h00) +
                   (digital_rate_trim[0] ? `RAT_PPM_LO : 6'h00);
  assign ppm_sum = ppm_acc + {3'h0, ppm_mag, 15'h0000};
  assign wrap = osc_tick_i && (presc == presc_top);

  always_comb begin
    presc_top = `RAT_PRESC_TOP;
    if (adj_pend) begin
      presc_top = digital_rate_trim[`RAT_DTR_SIGN_BIT] ? `RAT_PRESC_TOP + 16'h0001 :
                                                         `RAT_PRESC_TOP - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      presc <= 16'h0000;
      ppm_acc <= 24'h000000;
      adj_pend <= 1'b0;
      sec_tick_o <= 1'b0;
    end else begin
      sec_tick_o <= wrap;
      if (wrap) begin
        presc <= 16'h0000;
        if (ppm_sum >= `RAT_PPM_SCALE) begin
          ppm_acc <= ppm_sum - `RAT_PPM_SCALE;
          adj_pend <= 1'b1;
        end else begin
          ppm_acc <= ppm_sum;
          adj_pend <= 1'b0;
        end
      end else if (osc_tick_i) begin
        presc <= presc + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [24:0] low_cnt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt <= 25'h0000000;
    end else begin
      low_cnt <= irq_n_o ? 25'h0000000 : low_cnt + 25'h0000001;
    end
  end

  sequence s_pulse_trig;
    trigger && pulse_alarm_select && !pin_off;
  endsequence

  sequence s_pin_low;
    ##2 !irq_n_o;
  endsequence

  property p_flag_set;
    @(posedge clk_i) disable iff (!rstn_i) trigger |=> alarm_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set on match");

  property p_hold_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (irq_st == rat_pkg::RAT_HOLD && alarm_flag && !pin_off)[*2] |-> !irq_n_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("pin not held low in single mode");

  property p_pulse_start;
    @(posedge clk_i) disable iff (!rstn_i) s_pulse_trig ##1 !pin_off |-> ##1 !irq_n_o;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

  property p_pulse_len;
    @(posedge clk_i) disable iff (!rstn_i)
      ($rose(irq_n_o) && $past(irq_st, 2) == rat_pkg::RAT_PULSE && !$past(pin_off, 2))
      |-> low_cnt == 25'(PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");

  property p_fo_block;
    @(posedge clk_i) disable iff (!rstn_i) (freq_out_select != 4'h0)[*2] |-> irq_n_o && !trigger;
  endproperty
  a_fo_block: assert property (p_fo_block) else $error("alarm active with frequency output");

  property p_autoclear;
    @(posedge clk_i) disable iff (!rstn_i)
      (reg_rd_done_i && sr_pend && auto_clear_on_read && !set_during && !trigger) |=> !alarm_flag;
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("flag not cleared by read");

  property p_read_keep;
    @(posedge clk_i) disable iff (!rstn_i)
      (sr_pend && trigger && !reg_rd_done_i) ##1 (reg_rd_done_i && !sr_wr) |=> alarm_flag;
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("flag lost during read");

  property p_write_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      (sr_wr && !reg_wdata_i[`RAT_SR_FLAG_BIT] && !trigger) |=> !alarm_flag;
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("write of zero left flag set");

  property p_recur;
    @(posedge clk_i) disable iff (!rstn_i)
      s_pulse_trig and alarm_flag |-> s_pin_low;
  endproperty
  a_recur: assert property (p_recur) else $error("recurring pulse blocked by set flag");

endmodule

// >>> verif/rat_host_model.sv
// bus master model issuing register byte strobes
`timescale 1ns/1ps
module rat_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic done_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    done_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one byte per strobe; idle lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
  // end of a read transaction
  task automatic stop();
    @(negedge clk_i);
    done_o = 1'b1;
    @(negedge clk_i);
    done_o = 1'b0;
  endtask
endmodule

// >>> verif/tb_rat_core.sv
// self-checking bench of the alarm and trim block
`timescale 1ns/1ps
`include "rat_regs.svh"
module tb_rat_core;
  localparam int unsigned PW = 20;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic on_bat = 1'b0;
  logic upd = 1'b0;
  logic osc = 1'b1;
  logic [7:0] tf [6] = '{default: 8'h00};
  logic [7:0] v [6];
  logic wr, rd, done, sec_tick, irq_n;
  logic [7:0] addr, wdata, rdata, d, r, e;
  logic [3:0] fsel;
  logic [6:0] cx, cl;
  logic [15:0] lf = 16'h2B10;
  int err_count = 0;
  int checks_done = 0;
  int n, k;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  rat_core #(.PULSE_CYCLES(PW)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rd_done_i(done), .reg_rdata_o(rdata), .osc_tick_i(osc),
    .on_battery_i(on_bat), .time_upd_i(upd), .time_sec_i(tf[0]), .time_min_i(tf[1]), .time_hour_i(tf[2]),
    .time_date_i(tf[3]), .time_month_i(tf[4]), .time_wday_i(tf[5]), .sec_tick_o(sec_tick), .irq_n_o(irq_n),
    .freq_out_select_o(fsel), .cx_half_pf_o(cx), .cload_qtr_pf_o(cl));
  rat_host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .done_o(done), .addr_o(addr),
    .wdata_o(wdata));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] exp_cap(input logic [7:0] t, input logic b);
    logic [6:0] c;
    c = (t[5] ? 7'h00 : 7'h20) + {2'h0, t[4:0]} + `RAT_CX_BASE_HALF;
    if (b) begin
      case (t[7:6])
        2'h1: c = c - 7'h01;
        2'h2: c = c + 7'h01;
        2'h3: c = c + 7'h02;
        default: c = c;
      endcase
    end
    return c;
  endfunction
  function automatic void rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    r = lf[7:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one time update, then pin level two cycles on
  task automatic trig(input logic low);
    @(negedge clk_i);
    upd = 1'b1;
    @(negedge clk_i);
    upd = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({15'h0, irq_n}, {15'h0, ~low});
  endtask
  task automatic pwidth();
    // first low cycle already passed inside trig
    n = 1;
    while (irq_n === 1'b0 && n < 200) begin
      n++;
      @(negedge clk_i);
    end
    if (n == 200) begin
      err_count++;
      summarize();
    end
    chk(n[15:0], PW[15:0]);
  endtask
  task automatic wtick();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (sec_tick !== 1'b1 && n < 40000);
    if (n == 40000) begin
      err_count++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    chk({9'h0, cl}, 16'h0032);
    for (int a = 7; a < 19; a++) begin
      host.rd(a[7:0], d);
      chk(d, `RAT_RST_BYTE);
    end
    for (int a = 9; a < 19; a++) begin
      rnd();
      host.wr(a[7:0], r);
      host.rd(a[7:0], d);
      e = (a[7:0] == 8'h09 || a[7:0] == 8'h12) ? 8'h00 : (a[7:0] == 8'h0B) ? (r & 8'h07) : r;
      chk(d, e);
    end
    $display("test registers done");
    for (int i = 0; i < 64; i++) begin
      rnd();
      on_bat = r[2];
      osc = r[3];
      host.wr(`RAT_ADDR_ATRIM, {r[7:6], i[5:0]});
      @(negedge clk_i);
      chk({9'h0, cx}, {9'h0, exp_cap({r[7:6], i[5:0]}, r[2])});
      chk({9'h0, cl}, {9'h0, exp_cap({r[7:6], i[5:0]}, r[2])});
    end
    on_bat = 1'b0;
    osc = 1'b1;
    $display("test trim capacitors done");
    host.wr(`RAT_ADDR_DTRIM, 8'h03);
    wtick();
    wtick();
    chk(n[15:0], `RAT_PRESC_TOP);
    fork
      host.wr(`RAT_ADDR_DTRIM, 8'h07);
      wtick();
    join
    chk(n[15:0], `RAT_PRESC_TOP + 16'h0002);
    $display("test rate trim done");
    for (int i = 0; i < 6; i++) begin
      rnd();
      v[i] = {1'b1, r[6:0]};
      tf[i] = {r[0], r[6:0]};
      host.wr(`RAT_ADDR_ALM_BASE + i[7:0], v[i]);
    end
    host.wr(`RAT_ADDR_INTCTL, 8'h40);
    rnd();
    k = int'(r) % 6;
    tf[k][0] = ~tf[k][0];
    trig(1'b0);
    tf[k][0] = ~tf[k][0];
    trig(1'b1);
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h04);
    host.wr(`RAT_ADDR_STATUS, 8'h04);
    repeat (3) @(negedge clk_i);
    chk({15'h0, irq_n}, 16'h0000);
    host.wr(`RAT_ADDR_STATUS, 8'h00);
    repeat (3) @(negedge clk_i);
    chk({15'h0, irq_n}, 16'h0001);
    host.wr(`RAT_ADDR_ALM_BASE + k[7:0], v[k] & 8'h7F);
    tf[k][0] = ~tf[k][0];
    trig(1'b1);
    host.wr(`RAT_ADDR_STATUS, 8'h80);
    trig(1'b1);
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h84);
    // match one cycle before the end of the status read
    fork
      trig(1'b1);
      begin
        @(negedge clk_i);
        host.stop();
      end
    join
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h84);
    host.stop();
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h80);
    $display("test single alarm done");
    host.wr(`RAT_ADDR_INTCTL, 8'hC0);
    for (int i = 0; i < 2; i++) begin
      trig(1'b1);
      pwidth();
    end
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h84);
    $display("test recurring alarm done");
    host.wr(`RAT_ADDR_STATUS, 8'h00);
    for (int f = 1; f < 16; f++) begin
      host.wr(`RAT_ADDR_INTCTL, 8'h40 | f[7:0]);
      trig(1'b0);
      chk({12'h0, fsel}, f[15:0]);
    end
    host.rd(`RAT_ADDR_STATUS, d);
    chk(d, 8'h00);
    // pin off on battery, low again once back on main supply
    host.wr(`RAT_ADDR_INTCTL, 8'h50);
    on_bat = 1'b1;
    trig(1'b0);
    on_bat = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({15'h0, irq_n}, 16'h0000);
    host.wr(`RAT_ADDR_STATUS, 8'h00);
    host.wr(`RAT_ADDR_INTCTL, 8'h00);
    trig(1'b0);
    $display("test frequency select done");
    summarize();
  end
endmodule
